// ==== src/timer_pkg.sv ====
// Constants and types shared by the timer output compare unit
package timer_pkg;

    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_COUNT = 8'h04;
    localparam logic [7:0] OFF_CMP_A = 8'h08;
    localparam logic [7:0] OFF_CMP_B = 8'h0C;
    localparam logic [7:0] OFF_FLAGS = 8'h10;
    localparam logic [7:0] OFF_IRQ_EN = 8'h14;
    localparam logic [7:0] OFF_FORCE = 8'h18;
    localparam logic [7:0] OFF_PORT = 8'h1C;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int FLAG_OVF = 0;
    localparam int FLAG_A = 1;
    localparam int FLAG_B = 2;
    localparam int PORT_VAL_LSB = 0;
    localparam int PORT_DIR_LSB = 2;

    // ****************************************
    // Reset values and counter extremes
    // ****************************************
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] CMP_RST = 8'h00;
    localparam logic [2:0] FLAGS_RST = 3'h0;
    localparam logic [2:0] IRQ_EN_RST = 3'h0;
    localparam logic [3:0] PORT_RST = 4'h0;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hFF;

    // ****************************************
    // Compare output modes
    // ****************************************
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;

    // Control register, waveform mode in the low bits
    typedef struct packed {
        logic run;
        logic [1:0] compare_output_mode_b;
        logic [1:0] compare_output_mode_a;
        logic [2:0] waveform_gen_mode;
    } ctrl_s;

endpackage

// ==== src/timer_output_compare_unit.sv ====
// Timer output compare unit: counter, two compare channels, APB slave
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps

module timer_output_compare_unit (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] irq_ack,
    output logic [2:0] irq_req,
    output logic [1:0] pin_out,
    output logic [1:0] pin_oe
);

    // ****************************************
    // Helpers
    // ****************************************
    // Odd waveform modes are the PWM modes
    function automatic logic is_pwm(input logic [2:0] wgm);
        is_pwm = wgm[0];
    endfunction

    // Next output state from a match and from reaching bottom
    function automatic logic oc_next(input logic [1:0] com,
                                     input logic st,
                                     input logic match,
                                     input logic bottom);
        logic v;
        v = st;
        if (bottom) begin
            if (com == timer_pkg::COM_CLEAR) begin
                v = 1'b1;
            end else if (com == timer_pkg::COM_SET) begin
                v = 1'b0;
            end
        end
        if (match) begin
            case (com)
                timer_pkg::COM_TOGGLE: v = ~v;
                timer_pkg::COM_CLEAR: v = 1'b0;
                timer_pkg::COM_SET: v = 1'b1;
                default: v = v;
            endcase
        end
        oc_next = v;
    endfunction

    // ****************************************
    // State
    // ****************************************
    timer_pkg::ctrl_s ctrl, next_ctrl;
    logic [7:0] count, next_count;
    logic [7:0] cmp_act [2];
    logic [7:0] next_cmp_act [2];
    logic [7:0] cmp_buf [2];
    logic [7:0] next_cmp_buf [2];
    logic [2:0] flags, next_flags;
    logic [2:0] irq_en, next_irq_en;
    logic [1:0] port_val, next_port_val;
    logic [1:0] dir, next_dir;
    logic [1:0] oc_state, next_oc_state;
    logic block, next_block;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    logic [2:0] next_irq_req;
    logic [1:0] next_pin_out;
    logic [1:0] match;
    logic [1:0] com [2];
    logic access, wr, pwm, wr_count, at_bottom, mapped;

    assign access = psel & penable & pready;
    assign wr = access & pwrite;
    assign pwm = is_pwm(ctrl.waveform_gen_mode);
    assign wr_count = wr && paddr == timer_pkg::OFF_COUNT;
    assign com[0] = ctrl.compare_output_mode_a;
    assign com[1] = ctrl.compare_output_mode_b;
    // Counter is about to wrap from max to bottom
    assign at_bottom = ctrl.run && !wr_count &&
        count == timer_pkg::COUNT_MAX;

    always_comb begin
        case (paddr)
            timer_pkg::OFF_CTRL, timer_pkg::OFF_COUNT,
            timer_pkg::OFF_CMP_A, timer_pkg::OFF_CMP_B,
            timer_pkg::OFF_FLAGS, timer_pkg::OFF_IRQ_EN,
            timer_pkg::OFF_FORCE, timer_pkg::OFF_PORT: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_ctrl = ctrl;
        next_count = count;
        next_flags = flags;
        next_irq_en = irq_en;
        next_port_val = port_val;
        next_dir = dir;
        next_oc_state = oc_state;
        next_block = block;
        for (int i = 0; i < 2; i++) begin
            next_cmp_act[i] = cmp_act[i];
            next_cmp_buf[i] = cmp_buf[i];
        end

        // Stopped timer keeps the block until its next running cycle
        if (wr_count) begin
            next_block = 1'b1;
        end else if (ctrl.run) begin
            next_block = 1'b0;
        end

        // Counting ignores the waveform mode and follows only run; all modes count up
        if (wr_count) begin
            next_count = pwdata[7:0];
        end else if (ctrl.run) begin
            next_count = count + 8'h01;
        end

        for (int i = 0; i < 2; i++) begin
            match[i] = ctrl.run && !block &&
                count == cmp_act[i];
            // Output mode bits act at once, no shadow copy
            next_oc_state[i] = oc_next(com[i], oc_state[i], match[i],
                pwm && at_bottom);
            if (wr && !pwm && paddr == timer_pkg::OFF_FORCE &&
                pwdata[i]) begin
                next_oc_state[i] = oc_next(com[i], next_oc_state[i],
                    1'b1, 1'b0);
            end
            if (pwm && at_bottom) begin
                next_cmp_act[i] = cmp_buf[i];
            end
        end

        // Flag clear by write-one or service; a set in the same cycle wins
        if (wr && paddr == timer_pkg::OFF_FLAGS) begin
            next_flags = next_flags & ~pwdata[2:0];
        end
        next_flags = next_flags & ~irq_ack;
        if (match[0]) begin
            next_flags[timer_pkg::FLAG_A] = 1'b1;
        end
        if (match[1]) begin
            next_flags[timer_pkg::FLAG_B] = 1'b1;
        end
        if (at_bottom) begin
            next_flags[timer_pkg::FLAG_OVF] = 1'b1;
        end

        if (wr) begin
            case (paddr)
                timer_pkg::OFF_CTRL: begin
                    // Output state is untouched by a mode change
                    next_ctrl = timer_pkg::ctrl_s'(pwdata[7:0]);
                end
                timer_pkg::OFF_CMP_A, timer_pkg::OFF_CMP_B: begin
                    next_cmp_buf[paddr[2]] = pwdata[7:0];
                    if (!pwm) begin
                        next_cmp_act[paddr[2]] = pwdata[7:0];
                    end
                end
                timer_pkg::OFF_IRQ_EN: next_irq_en = pwdata[2:0];
                timer_pkg::OFF_PORT: begin
                    next_port_val = pwdata[timer_pkg::PORT_VAL_LSB +: 2];
                    next_dir = pwdata[timer_pkg::PORT_DIR_LSB +: 2];
                end
                default: next_block = next_block;
            endcase
        end

        next_irq_req = next_flags & next_irq_en;
        next_pin_out[0] = (next_ctrl.compare_output_mode_a !=
            timer_pkg::COM_OFF) ? next_oc_state[0] : next_port_val[0];
        next_pin_out[1] = (next_ctrl.compare_output_mode_b !=
            timer_pkg::COM_OFF) ? next_oc_state[1] : next_port_val[1];

        // ****************************************
        // APB: one wait state, registered answer
        // ****************************************
        next_pready = psel & penable & ~pready;
        next_pslverr = psel & penable & ~pready & ~mapped;
        next_prdata = 32'h00000000;
        if (psel && penable && !pready && !pwrite) begin
            case (paddr)
                timer_pkg::OFF_CTRL: next_prdata[7:0] = ctrl;
                timer_pkg::OFF_COUNT: next_prdata[7:0] = count;
                timer_pkg::OFF_CMP_A: next_prdata[7:0] =
                    pwm ? cmp_buf[0] : cmp_act[0];
                timer_pkg::OFF_CMP_B: next_prdata[7:0] =
                    pwm ? cmp_buf[1] : cmp_act[1];
                timer_pkg::OFF_FLAGS: next_prdata[2:0] = flags;
                timer_pkg::OFF_IRQ_EN: next_prdata[2:0] = irq_en;
                timer_pkg::OFF_PORT: next_prdata[3:0] = {dir, port_val};
                default: next_prdata = 32'h00000000;
            endcase
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl <= timer_pkg::ctrl_s'(timer_pkg::CTRL_RST);
            count <= timer_pkg::COUNT_RST;
            for (int i = 0; i < 2; i++) begin
                cmp_act[i] <= timer_pkg::CMP_RST;
                cmp_buf[i] <= timer_pkg::CMP_RST;
            end
            flags <= timer_pkg::FLAGS_RST;
            irq_en <= timer_pkg::IRQ_EN_RST;
            port_val <= timer_pkg::PORT_RST[1:0];
            dir <= timer_pkg::PORT_RST[3:2];
            oc_state <= 2'h0;
            block <= 1'b0;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq_req <= 3'h0;
            pin_out <= 2'h0;
            pin_oe <= 2'h0;
        end else begin
            ctrl <= next_ctrl;
            count <= next_count;
            cmp_act <= next_cmp_act;
            cmp_buf <= next_cmp_buf;
            flags <= next_flags;
            irq_en <= next_irq_en;
            port_val <= next_port_val;
            dir <= next_dir;
            oc_state <= next_oc_state;
            block <= next_block;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            irq_req <= next_irq_req;
            pin_out <= next_pin_out;
            pin_oe <= next_dir;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_flag_after_match;
        match[0] |=> flags[timer_pkg::FLAG_A];
    endproperty
    a_flag_after_match: assert property (p_flag_after_match)
        else $error("match A did not set its flag");

    property p_equal_matches;
        ctrl.run && !block && count == cmp_act[1] |=>
            flags[timer_pkg::FLAG_B];
    endproperty
    a_equal_matches: assert property (p_equal_matches)
        else $error("equality on channel B not flagged");

    property p_w1c;
        wr && paddr == timer_pkg::OFF_FLAGS && pwdata[1] && !match[0]
            |=> !flags[timer_pkg::FLAG_A];
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("write one did not clear flag A");

    property p_irq;
        irq_req == (flags & irq_en) &&
            !($past(irq_ack[0] && !at_bottom) && flags[timer_pkg::FLAG_OVF]);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt request does not follow flags");

    property p_buffered;
        pwm && !at_bottom |=> $stable(cmp_act[0]);
    endproperty
    a_buffered: assert property (p_buffered)
        else $error("active compare changed mid sequence");

    property p_direct;
        wr && !pwm && paddr == timer_pkg::OFF_CMP_A |=>
            cmp_act[0] == $past(pwdata[7:0]);
    endproperty
    a_direct: assert property (p_direct)
        else $error("direct compare write lost");

    property p_block;
        wr_count |=> !match[0] && !match[1];
    endproperty
    a_block: assert property (p_block)
        else $error("match not blocked after counter write");

    property p_force_no_flag;
        wr && paddr == timer_pkg::OFF_FORCE && !match[0] &&
            !flags[timer_pkg::FLAG_A] |=> !flags[timer_pkg::FLAG_A];
    endproperty
    a_force_no_flag: assert property (p_force_no_flag)
        else $error("force strobe set the match flag");

    property p_toggle;
        match[0] && !pwm && com[0] == timer_pkg::COM_TOGGLE &&
            !(wr && paddr == timer_pkg::OFF_FORCE) |=>
            oc_state[0] != $past(oc_state[0]);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("toggle mode did not toggle");

    property p_pin_mux;
        pin_out[1] == ((com[1] != timer_pkg::COM_OFF) ?
            oc_state[1] : port_val[1]) && pin_oe == dir;
    endproperty
    a_pin_mux: assert property (p_pin_mux)
        else $error("pin override or direction wrong");

    property p_wrap;
        at_bottom |=> count == timer_pkg::COUNT_BOTTOM &&
            flags[timer_pkg::FLAG_OVF];
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("wrap or overflow flag wrong");

    property p_write_wins;
        wr_count && ctrl.run |=> count == $past(pwdata[7:0]);
    endproperty
    a_write_wins: assert property (p_write_wins)
        else $error("counter write lost to count");

    c_match_a: cover property (match[0] ##1 flags[timer_pkg::FLAG_A]);
    c_force: cover property (wr && paddr == timer_pkg::OFF_FORCE);
    c_pwm_reload: cover property (pwm && at_bottom);
    c_overflow: cover property (at_bottom ##1 irq_req[0]);

endmodule

// ==== test/pin_pad.sv ====
// Pad model for one compare pin, with a weak pull-up when released
`timescale 1ns/1ps

module pin_pad (
    input wire logic drive,
    input wire logic enable,
    output logic level
);

    // ****************************************
    // Pad level
    // ****************************************
    // A released pad must not show the last driven value
    assign level = enable ? drive : 1'b1;

endmodule

// ==== test/tb.sv ====
// Self-checking bench for the timer output compare unit
`timescale 1ns/1ps

module tb;

    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] irq_ack = 3'h0;
    logic [2:0] irq_req;
    logic [1:0] pin_out;
    logic [1:0] pin_oe;
    logic [1:0] pad;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;
    logic [31:0] r;
    logic e;

    timer_output_compare_unit i_timer_output_compare_unit (
        .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq_ack(irq_ack),
        .irq_req(irq_req), .pin_out(pin_out), .pin_oe(pin_oe)
    );

    pin_pad i_pin_pad_a (.drive(pin_out[0]), .enable(pin_oe[0]),
        .level(pad[0]));
    pin_pad i_pin_pad_b (.drive(pin_out[1]), .enable(pin_oe[1]),
        .level(pad[1]));

    always #4 clk_sys = ~clk_sys;

    // ****************************************
    // Closing and hang guard
    // ****************************************
    task automatic conclude();
        if (bad_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            $display("BAD cycles expected below 20000 seen 20000");
            conclude();
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input string n, input logic [31:0] x,
                       input logic [31:0] g);
        checks++;
        if (g !== x) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, x, g);
        end
    endtask

    // Holds the request until pready is sampled high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        // Start on a fresh edge: no strobe is driven twice in one step
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            bad_count++;
            $display("BAD pready expected 1 seen 0");
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x,
                      input string n);
        apb(1'b0, a, 32'h0);
        chk(n, x, r);
    endtask

    function automatic logic [31:0] ctl(logic run, logic [1:0] cb,
                                        logic [1:0] ca, logic [2:0] w);
        timer_pkg::ctrl_s c;
        c.run = run;
        c.compare_output_mode_b = cb;
        c.compare_output_mode_a = ca;
        c.waveform_gen_mode = w;
        return {24'h0, c};
    endfunction

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        rd(timer_pkg::OFF_CTRL, 32'h0, "ctrl");
        rd(timer_pkg::OFF_COUNT, 32'h0, "count");
        rd(timer_pkg::OFF_CMP_A, 32'h0, "cmp_a");
        rd(timer_pkg::OFF_FLAGS, 32'h0, "flags");
        rd(timer_pkg::OFF_PORT, 32'h0, "port");
        chk("pad_released", 32'h3, {30'h0, pad});
        rd(8'h20, 32'h0, "unmapped");
        chk("slverr", 32'h1, {31'h0, e});
    endtask

    task automatic t_match();
        apb(1'b1, timer_pkg::OFF_PORT, 32'h4);
        apb(1'b1, timer_pkg::OFF_IRQ_EN, 32'h7);
        apb(1'b1, timer_pkg::OFF_CMP_A, 32'h5);
        apb(1'b1, timer_pkg::OFF_COUNT, 32'h2);
        apb(1'b1, timer_pkg::OFF_CTRL, ctl(1, 0, timer_pkg::COM_TOGGLE, 0));
        settle(3);
        chk("irq_a_early", 32'h0, {31'h0, irq_req[1]});
        settle(1);
        chk("irq_a", 32'h1, {31'h0, irq_req[1]});
        chk("pin_a_toggled", 32'h1, {31'h0, pad[0]});
        apb(1'b1, timer_pkg::OFF_CTRL, ctl(0, 0, timer_pkg::COM_TOGGLE, 0));
        apb(1'b1, timer_pkg::OFF_FLAGS, 32'h0);
        rd(timer_pkg::OFF_FLAGS, 32'h2, "flag_kept");
        apb(1'b1, timer_pkg::OFF_FLAGS, 32'h2);
        rd(timer_pkg::OFF_FLAGS, 32'h0, "flag_cleared");
    endtask

    task automatic t_ovf();
        apb(1'b1, timer_pkg::OFF_COUNT, 32'hFE);
        apb(1'b1, timer_pkg::OFF_CTRL, ctl(1, 0, 0, 0));
        settle(1);
        chk("ovf_early", 32'h0, {31'h0, irq_req[0]});
        settle(1);
        chk("ovf_wrap", 32'h1, {31'h0, irq_req[0]});
        apb(1'b1, timer_pkg::OFF_CTRL, ctl(0, 0, 0, 0));
        #1;
        chk("irq_b", 32'h1, {31'h0, irq_req[2]});
        apb(1'b1, timer_pkg::OFF_IRQ_EN, 32'h0);
        #1;
        chk("ovf_masked", 32'h0, {31'h0, irq_req[0]});
        rd(timer_pkg::OFF_FLAGS, 32'h5, "ovf_held");
        irq_ack <= 3'h5;
        @(posedge clk_sys);
        irq_ack <= 3'h0;
        rd(timer_pkg::OFF_FLAGS, 32'h0, "ovf_serviced");
    endtask

    task automatic t_block();
        apb(1'b1, timer_pkg::OFF_CMP_B, 32'h40);
        apb(1'b1, timer_pkg::OFF_COUNT, 32'h40);
        apb(1'b1, timer_pkg::OFF_CTRL, ctl(1, 0, 0, 0));
        apb(1'b1, timer_pkg::OFF_CTRL, ctl(0, 0, 0, 0));
        rd(timer_pkg::OFF_FLAGS, 32'h0, "blocked_b");
    endtask

    task automatic t_force();
        logic [1:0] m [5] = '{timer_pkg::COM_SET, timer_pkg::COM_CLEAR,
            timer_pkg::COM_TOGGLE, timer_pkg::COM_TOGGLE, timer_pkg::COM_SET};
        logic x [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, timer_pkg::OFF_CTRL, ctl(0, 0, m[i], 0));
            apb(1'b1, timer_pkg::OFF_FORCE, 32'h1);
            settle(3);
            chk("force_a", {31'h0, x[i]}, {31'h0, pad[0]});
        end
        rd(timer_pkg::OFF_FLAGS, 32'h0, "force_no_flag");
        apb(1'b1, timer_pkg::OFF_PORT, 32'hC);
        apb(1'b1, timer_pkg::OFF_CTRL,
            ctl(0, timer_pkg::COM_SET, timer_pkg::COM_TOGGLE, 0));
        apb(1'b1, timer_pkg::OFF_FORCE, 32'h2);
        settle(1);
        chk("force_b", 32'h1, {31'h0, pad[1]});
        chk("force_a_kept", 32'h1, {31'h0, pad[0]});
        apb(1'b1, timer_pkg::OFF_CTRL, ctl(0, 0, timer_pkg::COM_OFF, 0));
        apb(1'b1, timer_pkg::OFF_FORCE, 32'h1);
        apb(1'b1, timer_pkg::OFF_PORT, 32'h4);
        settle(3);
        chk("port_value", 32'h0, {31'h0, pad[0]});
        apb(1'b1, timer_pkg::OFF_CTRL, ctl(0, 0, timer_pkg::COM_TOGGLE, 1));
        settle(3);
        chk("state_kept", 32'h1, {31'h0, pad[0]});
        apb(1'b1, timer_pkg::OFF_FORCE, 32'h1);
        settle(3);
        chk("pwm_no_force", 32'h1, {31'h0, pad[0]});
    endtask

    task automatic t_buffer();
        apb(1'b1, timer_pkg::OFF_CTRL, ctl(0, 0, 0, 0));
        apb(1'b1, timer_pkg::OFF_CMP_A, 32'h10);
        apb(1'b1, timer_pkg::OFF_CTRL, ctl(0, 0, 0, 1));
        apb(1'b1, timer_pkg::OFF_CMP_A, 32'h20);
        rd(timer_pkg::OFF_CMP_A, 32'h20, "buffer_read");
        apb(1'b1, timer_pkg::OFF_COUNT, 32'h1E);
        apb(1'b1, timer_pkg::OFF_FLAGS, 32'h7);
        apb(1'b1, timer_pkg::OFF_CTRL, ctl(1, 0, 0, 1));
        settle(4);
        apb(1'b1, timer_pkg::OFF_CTRL, ctl(0, 0, 0, 1));
        rd(timer_pkg::OFF_FLAGS, 32'h0, "active_held");
        apb(1'b1, timer_pkg::OFF_CMP_A, 32'h01);
        apb(1'b1, timer_pkg::OFF_COUNT, 32'hFE);
        apb(1'b1, timer_pkg::OFF_CTRL, ctl(1, 0, 0, 1));
        settle(5);
        apb(1'b1, timer_pkg::OFF_CTRL, ctl(0, 0, 0, 1));
        rd(timer_pkg::OFF_FLAGS, 32'h3, "reloaded_a");
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_match();
        t_ovf();
        t_block();
        t_force();
        t_buffer();
        conclude();
    end

endmodule
